/* logic/ddscr_bank.sv */
// Per-channel control register bank of a four-channel synthesizer core.
// Assumes the serial port front end delivers decoded word writes in the ref_clk domain.
// Functional notes
// - Global auto sweep clear zeros sweep at update.
// - Function bit 0 picks sine over cosine.
// - Function bit 1 holds phase accumulator cleared.
// - Function bit 2 zeros phase accumulator at update.
// - Function bit 3 holds sweep accumulator cleared.
// - Function bit 4 zeros sweep accumulator at update.
// - Function bit 5 enables matched pipeline delay.
// - Function bit 6 powers down the converter.
// - Function bit 7 powers down the digital core.
// - Sweep ramp timer reloads at update if bit 13.
// - Function bit 14 enables linear sweep.
// - No-dwell bit ignored while sweep disabled.
// - Bits 18-16 alignment; bits 21-19 inactive.
// - Bits 23-22 select modulation target.
// - Each channel holds its own frequency word.
// - Phase register holds 14-bit offset word.
// - Amplitude bits 9-0 hold scale factor.
// - Multiplier disabled and bypassed when bit 12 clear.
// - Amplitude ramp timer reloads at update if bit 10.
// - Auto ramp bit valid only with multiplier on.
// - Step size, ramp rate fields; bit 13 inactive.
// - Channel holds ramp rate and rising delta.
// - Channel holds falling delta word.
// - Writes reach only channels enabled in mask.
`timescale 1ns/1ns
`include "ddscr_defs.svh"
module ddscr_bank #(
  parameter int NUM_CH = `DDSCR_NUM_CHANNELS
) (
  ref_clk,
  sys_rst,
  clk_en,
  wr,
  io_update,
  profile_change,
  ctl,
  phase_clr_async,
  sweep_clr_async,
  chan_en,
  rd_addr,
  rd_chan,
  rd_data
);
  input wire logic ref_clk;
  input wire logic sys_rst;
  input wire logic clk_en;
  input wire ddscr_pkg::ddscr_wr_t wr;
  input wire logic io_update;
  input wire logic profile_change;
  output ddscr_pkg::ddscr_ctl_t [3:0] ctl;
  output logic [3:0] phase_clr_async;
  output logic [3:0] sweep_clr_async;
  output logic [3:0] chan_en;
  input wire logic [4:0] rd_addr;
  input wire logic [1:0] rd_chan;
  output logic [31:0] rd_data;

  ddscr_pkg::ddscr_state_vec_t st_r;
  ddscr_pkg::ddscr_state_vec_t st_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic upd_first;

  // Decodes the word view of a channel register; used by readback only.
  function automatic logic [31:0] chan_word(input ddscr_pkg::ddscr_chan_t c,
                                            input logic [4:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      `DDSCR_ADDR_CHANNEL_FUNCTION: w = {8'h00, c.function_word};
      `DDSCR_ADDR_FREQUENCY_WORD: w = c.frequency_word;
      `DDSCR_ADDR_PHASE_OFFSET: w = {16'h0000, c.phase_offset};
      `DDSCR_ADDR_AMPLITUDE_CONTROL: w = {8'h00, c.amplitude};
      `DDSCR_ADDR_SWEEP_RAMP_RATE: w = {16'h0000, c.ramp_rate};
      `DDSCR_ADDR_RISING_DELTA: w = c.rising_delta;
      `DDSCR_ADDR_FALLING_DELTA: w = c.falling_delta;
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  // Builds the decoded controls of one channel from its active words.
  function automatic ddscr_pkg::ddscr_ctl_t decode(input ddscr_pkg::ddscr_chan_t c,
                                                   input logic [15:0] g2,
                                                   input logic upd,
                                                   input logic prof);
    ddscr_pkg::ddscr_ctl_t d;
    d = '0;
    d.sine_sel = c.function_word[`DDSCR_CFN_SINE];
    // The global clear bits are folded in here so the clear pins leave a flop directly.
    d.phase_clr_async = c.function_word[`DDSCR_CFN_CLR_PHASE] |
                        g2[`DDSCR_GF2_CLR_PHASE];
    d.phase_load_zero = upd & (c.function_word[`DDSCR_CFN_AUTO_CLR_PHASE] |
                        g2[`DDSCR_GF2_AUTO_CLR_PHASE]);
    d.sweep_clr_async = c.function_word[`DDSCR_CFN_CLR_SWEEP] |
                        g2[`DDSCR_GF2_CLR_SWEEP];
    d.sweep_load_zero = upd & (c.function_word[`DDSCR_CFN_AUTO_CLR_SWEEP] |
                        g2[`DDSCR_GF2_AUTO_CLR_SWEEP]);
    d.match_pipe = c.function_word[`DDSCR_CFN_MATCH_PIPE];
    d.conv_pdn = c.function_word[`DDSCR_CFN_CONV_PDN];
    d.dig_pdn = c.function_word[`DDSCR_CFN_DIG_PDN];
    d.lsb_ctl = c.function_word[`DDSCR_CFN_LSB_CTL_LSB +: 2];
    d.sweep_rr_reload = upd & c.function_word[`DDSCR_CFN_SWEEP_RR_LOAD];
    d.sweep_en = c.function_word[`DDSCR_CFN_SWEEP_EN];
    d.no_dwell = c.function_word[`DDSCR_CFN_NO_DWELL] &
                 c.function_word[`DDSCR_CFN_SWEEP_EN];
    d.align = c.function_word[`DDSCR_CFN_ALIGN_LSB +: 3];
    d.mod_sel = c.function_word[`DDSCR_CFN_MOD_SEL_LSB +: 2];
    d.freq_word = c.frequency_word;
    d.phase_word = c.phase_offset[13:0];
    d.amp_scale = c.amplitude[`DDSCR_ACR_SCALE_LSB +: 10];
    d.mult_en = c.amplitude[`DDSCR_ACR_MULT_EN];
    d.amp_rr_reload = (upd | prof) & c.amplitude[`DDSCR_ACR_RR_LOAD];
    d.auto_ramp = c.amplitude[`DDSCR_ACR_AUTO_RAMP] &
                  c.amplitude[`DDSCR_ACR_MULT_EN];
    d.amp_step = c.amplitude[`DDSCR_ACR_STEP_LSB +: 2];
    d.amp_rate = c.amplitude[`DDSCR_ACR_RATE_LSB +: 8];
    d.sweep_rate = c.ramp_rate;
    d.rise_delta = c.rising_delta;
    d.fall_delta = c.falling_delta;
    return d;
  endfunction

  always_comb begin
    // A strobe held high still gives one-cycle zero loads, since only the idle state arms them.
    upd_first = io_update && (st_r.state == ddscr_pkg::DDSCR_IDLE);
    st_nxt = st_r;
    rd_nxt = rd_r;
    if (wr.we) begin
      case (wr.addr)
        `DDSCR_ADDR_CHANNEL_SELECT: st_nxt.chan_sel = wr.wdata[7:0];
        `DDSCR_ADDR_GLOBAL_FUNC_TWO: st_nxt.gfunc_two = wr.wdata[15:0];
        default: begin
        end
      endcase
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // The mask is read from its register, so a write in the same cycle as a mask change uses the old mask.
      if (wr.we && st_r.chan_sel[`DDSCR_CSR_EN_LSB + i]) begin
        case (wr.addr)
          `DDSCR_ADDR_CHANNEL_FUNCTION:
            st_nxt.staged[i].function_word = wr.wdata[23:0] & `DDSCR_CFN_WRITABLE;
          `DDSCR_ADDR_FREQUENCY_WORD: st_nxt.staged[i].frequency_word = wr.wdata;
          `DDSCR_ADDR_PHASE_OFFSET:
            st_nxt.staged[i].phase_offset = wr.wdata[15:0] & `DDSCR_POW_WRITABLE;
          `DDSCR_ADDR_AMPLITUDE_CONTROL:
            st_nxt.staged[i].amplitude = wr.wdata[23:0] & `DDSCR_ACR_WRITABLE;
          `DDSCR_ADDR_SWEEP_RAMP_RATE: st_nxt.staged[i].ramp_rate = wr.wdata[15:0];
          `DDSCR_ADDR_RISING_DELTA: st_nxt.staged[i].rising_delta = wr.wdata;
          `DDSCR_ADDR_FALLING_DELTA: st_nxt.staged[i].falling_delta = wr.wdata;
          default: begin
          end
        endcase
      end
      if (io_update) begin
        st_nxt.active[i] = st_nxt.staged[i];
      end
      st_nxt.ctl[i] = decode(st_nxt.active[i], st_nxt.gfunc_two, upd_first, profile_change);
    end
    case (st_r.state)
      ddscr_pkg::DDSCR_IDLE: begin
        if (io_update) begin
          st_nxt.state = ddscr_pkg::DDSCR_APPLY;
        end
      end
      ddscr_pkg::DDSCR_APPLY: begin
        if (!io_update) begin
          st_nxt.state = ddscr_pkg::DDSCR_IDLE;
        end
      end
      default: st_nxt.state = ddscr_pkg::DDSCR_IDLE;
    endcase
    if (rd_addr == `DDSCR_ADDR_CHANNEL_SELECT) begin
      rd_nxt = {24'h000000, st_r.chan_sel};
    end else if (rd_addr == `DDSCR_ADDR_GLOBAL_FUNC_TWO) begin
      rd_nxt = {16'h0000, st_r.gfunc_two};
    end else begin
      rd_nxt = chan_word(st_r.active[rd_chan], rd_addr);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.chan_sel <= `DDSCR_CSR_RESET;
      rd_r <= 32'h0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Clear levels come straight from the ctl flops; the core applies them asynchronously.
  always_comb begin
    ctl = st_r.ctl;
    rd_data = rd_r;
    chan_en = st_r.chan_sel[`DDSCR_CSR_EN_LSB +: 4];
    for (int i = 0; i < 4; i++) begin
      phase_clr_async[i] = st_r.ctl[i].phase_clr_async;
      sweep_clr_async[i] = st_r.ctl[i].sweep_clr_async;
    end
  end
endmodule

/* logic/ddscr_defs.svh */
// Register offsets, field positions and reset values of the channel register bank.
// Included by the package and the register bank; definitions only.
`ifndef DDSCR_DEFS_SVH
`define DDSCR_DEFS_SVH
`define DDSCR_ADDR_CHANNEL_SELECT 5'h00
`define DDSCR_ADDR_GLOBAL_FUNC_TWO 5'h02
`define DDSCR_ADDR_CHANNEL_FUNCTION 5'h03
`define DDSCR_ADDR_FREQUENCY_WORD 5'h04
`define DDSCR_ADDR_PHASE_OFFSET 5'h05
`define DDSCR_ADDR_AMPLITUDE_CONTROL 5'h06
`define DDSCR_ADDR_SWEEP_RAMP_RATE 5'h07
`define DDSCR_ADDR_RISING_DELTA 5'h08
`define DDSCR_ADDR_FALLING_DELTA 5'h09
`define DDSCR_CSR_EN_LSB 4
`define DDSCR_GF2_AUTO_CLR_PHASE 13
`define DDSCR_GF2_AUTO_CLR_SWEEP 15
`define DDSCR_GF2_CLR_PHASE 12
`define DDSCR_GF2_CLR_SWEEP 14
`define DDSCR_CFN_SINE 0
`define DDSCR_CFN_CLR_PHASE 1
`define DDSCR_CFN_AUTO_CLR_PHASE 2
`define DDSCR_CFN_CLR_SWEEP 3
`define DDSCR_CFN_AUTO_CLR_SWEEP 4
`define DDSCR_CFN_MATCH_PIPE 5
`define DDSCR_CFN_CONV_PDN 6
`define DDSCR_CFN_DIG_PDN 7
`define DDSCR_CFN_LSB_CTL_LSB 8
`define DDSCR_CFN_SWEEP_RR_LOAD 13
`define DDSCR_CFN_SWEEP_EN 14
`define DDSCR_CFN_NO_DWELL 15
`define DDSCR_CFN_ALIGN_LSB 16
`define DDSCR_CFN_MOD_SEL_LSB 22
`define DDSCR_CFN_WRITABLE 24'hc7e3ff
`define DDSCR_ACR_SCALE_LSB 0
`define DDSCR_ACR_RR_LOAD 10
`define DDSCR_ACR_AUTO_RAMP 11
`define DDSCR_ACR_MULT_EN 12
`define DDSCR_ACR_STEP_LSB 14
`define DDSCR_ACR_RATE_LSB 16
`define DDSCR_ACR_WRITABLE 24'hffdfff
`define DDSCR_POW_WRITABLE 16'h3fff
`define DDSCR_CSR_RESET 8'hf0
`define DDSCR_NUM_CHANNELS 4
`endif

/* logic/ddscr_pkg.sv */
// Types shared by the channel register bank and its surroundings.
// Includes ddscr_defs.svh; its field widths are written out directly.
`include "ddscr_defs.svh"
package ddscr_pkg;
  typedef struct packed {
    logic [23:0] function_word;
    logic [31:0] frequency_word;
    logic [15:0] phase_offset;
    logic [23:0] amplitude;
    logic [15:0] ramp_rate;
    logic [31:0] rising_delta;
    logic [31:0] falling_delta;
  } ddscr_chan_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [31:0] wdata;
  } ddscr_wr_t;

  typedef struct packed {
    logic sine_sel;
    logic phase_clr_async;
    logic phase_load_zero;
    logic sweep_clr_async;
    logic sweep_load_zero;
    logic match_pipe;
    logic conv_pdn;
    logic dig_pdn;
    logic [1:0] lsb_ctl;
    logic sweep_rr_reload;
    logic sweep_en;
    logic no_dwell;
    logic [2:0] align;
    logic [1:0] mod_sel;
    logic [31:0] freq_word;
    logic [13:0] phase_word;
    logic [9:0] amp_scale;
    logic mult_en;
    logic amp_rr_reload;
    logic auto_ramp;
    logic [1:0] amp_step;
    logic [7:0] amp_rate;
    logic [15:0] sweep_rate;
    logic [31:0] rise_delta;
    logic [31:0] fall_delta;
  } ddscr_ctl_t;

  typedef enum logic [1:0] {
    DDSCR_IDLE,
    DDSCR_APPLY
  } ddscr_state_t;

  typedef struct packed {
    ddscr_state_t state;
    logic [7:0] chan_sel;
    logic [15:0] gfunc_two;
    ddscr_chan_t [3:0] staged;
    ddscr_chan_t [3:0] active;
    ddscr_ctl_t [3:0] ctl;
  } ddscr_state_vec_t;
endpackage

/* sim/ddscr_checker.sv */
// Assertion checker for the channel register bank.
// Sees only the bank's ports; bound to every ddscr_bank instance.
`timescale 1ns/1ns
module ddscr_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire ddscr_pkg::ddscr_wr_t wr,
  input wire logic io_update,
  input wire logic profile_change,
  input wire ddscr_pkg::ddscr_ctl_t [3:0] ctl,
  input wire logic [3:0] phase_clr_async,
  input wire logic [3:0] sweep_clr_async,
  input wire logic [3:0] chan_en,
  input wire logic [4:0] rd_addr,
  input wire logic [1:0] rd_chan,
  input wire logic [31:0] rd_data
);
  logic [3:0] pz, sz, sr, ar;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pz[i] = ctl[i].phase_load_zero;
      sz[i] = ctl[i].sweep_load_zero;
      sr[i] = ctl[i].sweep_rr_reload;
      ar[i] = ctl[i].amp_rr_reload;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_sel_wr; clk_en && wr.we && wr.addr == 5'h00; endsequence
  sequence s_upd_seen; $past(io_update); endsequence
  property p_sel; s_sel_wr |=> chan_en == $past(wr.wdata[7:4]); endproperty
  property p_pz; pz != 4'h0 |-> s_upd_seen; endproperty
  property p_sz; sz != 4'h0 |-> s_upd_seen; endproperty
  property p_sr; sr != 4'h0 |-> s_upd_seen; endproperty
  property p_ar; ar != 4'h0 |-> $past(io_update || profile_change); endproperty
  property p_pca; ctl[0].phase_clr_async |-> phase_clr_async[0]; endproperty
  property p_sca; ctl[0].sweep_clr_async |-> sweep_clr_async[0]; endproperty
  property p_hold; !$past(io_update) |-> $stable(ctl[0].freq_word); endproperty
  property p_pinact; $past(clk_en) && $past(rd_addr) == 5'h05 |-> rd_data[31:14] == 18'h0;
  endproperty
  property p_pz_one; pz != 4'h0 && clk_en |=> pz == 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("select mask not taken");
  a_pz: assert property (p_pz) else $error("phase zero without update");
  a_pz_one: assert property (p_pz_one) else $error("phase zero longer than a cycle");
  a_sz: assert property (p_sz) else $error("sweep zero without update");
  a_sr: assert property (p_sr) else $error("sweep reload without update");
  a_ar: assert property (p_ar) else $error("amp reload without cause");
  a_pca: assert property (p_pca) else $error("phase clear not driven");
  a_sca: assert property (p_sca) else $error("sweep clear not driven");
  a_hold: assert property (p_hold) else $error("active word moved");
  a_pinact: assert property (p_pinact) else $error("phase inactive bits set");
endmodule

bind ddscr_bank ddscr_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .wr(wr), .io_update(io_update), .profile_change(profile_change), .ctl(ctl),
  .phase_clr_async(phase_clr_async), .sweep_clr_async(sweep_clr_async), .chan_en(chan_en),
  .rd_addr(rd_addr), .rd_chan(rd_chan), .rd_data(rd_data));

/* sim/ddscr_host.sv */
// Host model: drives word writes and the update strobe of the bank.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
module ddscr_host (
  input wire logic ref_clk,
  output ddscr_pkg::ddscr_wr_t wr,
  output logic io_update
);
  initial begin
    wr = '{1'b0, 5'h1f, 32'h0};
    io_update = 1'b0;
  end
  // The idle bus shows the inverse word, so stale data never looks like a write.
  task automatic wr_word(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= '{1'b1, a, (a == 5'h03) ? (d & ~32'h400) : d};
    @(posedge ref_clk);
    wr <= '{1'b0, ~a, ~d};
  endtask
  task automatic pulse(input int n = 1);
    @(posedge ref_clk);
    io_update <= 1'b1;
    repeat (n) @(posedge ref_clk);
    io_update <= 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench of the channel register bank.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ns
module testbench;
  logic ref_clk, sys_rst, clk_en, profile_change, io_update;
  logic [4:0] rd_addr;
  logic [1:0] rd_chan;
  ddscr_pkg::ddscr_wr_t wr;
  ddscr_pkg::ddscr_ctl_t [3:0] ctl;
  logic [3:0] phase_clr_async, sweep_clr_async, chan_en, sz;
  logic [31:0] rd_data, d, lv;
  logic [31:0] exp_r [4][32];
  int fail_count, n_checks, seed;
  ddscr_host host (.ref_clk(ref_clk), .wr(wr), .io_update(io_update));
  ddscr_bank uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .wr(wr),
    .io_update(io_update), .profile_change(profile_change), .ctl(ctl),
    .phase_clr_async(phase_clr_async), .sweep_clr_async(sweep_clr_async),
    .chan_en(chan_en), .rd_addr(rd_addr), .rd_chan(rd_chan), .rd_data(rd_data));
  function automatic logic [31:0] wmask(input int a);
    case (a)
      3: return 32'h00c7e3ff;
      5: return 32'h00003fff;
      6: return 32'h00ffdfff;
      7: return 32'h0000ffff;
      default: return 32'hffffffff;
    endcase
  endfunction
  function automatic logic [31:0] exp_lvl(input int c);
    logic [23:0] f;
    logic [23:0] m;
    f = exp_r[c][3][23:0];
    m = exp_r[c][6][23:0];
    return {4'h0, f[23:22], f[18:16], f[15] & f[14], f[9:8], f[7:5], m[11] & m[12], m[15:14],
            m[23:16], 6'h0};
  endfunction
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic rd(input int a, input int c);
    @(posedge ref_clk);
    rd_addr <= a[4:0];
    rd_chan <= c[1:0];
    @(posedge ref_clk);
    #1 check("rd_data", exp_r[c][a], rd_data);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    seed = 32'h0977;
    {sys_rst, clk_en, profile_change, rd_addr, rd_chan} = {3'b110, 7'h0};
    foreach (exp_r[c, a]) exp_r[c][a] = 32'h0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1 check("chan_en", 32'hf, {28'h0, chan_en});
    rd(3, 1);
    for (int c = 0; c < 4; c++) begin
      host.wr_word(5'h00, 32'h10 << c);
      for (int a = 3; a < 10; a++) begin
        d = $random(seed);
        host.wr_word(a[4:0], d);
        if (a == 4) rd(4, c);
        exp_r[c][a] = d & wmask(a);
      end
      host.pulse();
      for (int a = 3; a < 10; a++) rd(a, c);
      check("freq_word", exp_r[c][4], ctl[c].freq_word);
      check("sine_sel", {31'h0, exp_r[c][3][0]}, {31'h0, ctl[c].sine_sel});
      check("mult_en", {31'h0, exp_r[c][6][12]}, {31'h0, ctl[c].mult_en});
      lv = {4'h0, ctl[c].mod_sel, ctl[c].align, ctl[c].no_dwell, ctl[c].lsb_ctl, ctl[c].dig_pdn,
            ctl[c].conv_pdn, ctl[c].match_pipe, ctl[c].auto_ramp, ctl[c].amp_step,
            ctl[c].amp_rate, 6'h0};
      check("levels", exp_lvl(c), lv);
      check("phase_word", exp_r[c][5], {18'h0, ctl[c].phase_word});
      check("amp_scale", exp_r[c][6] & 32'h3ff, {22'h0, ctl[c].amp_scale});
      check("sweep_rate", exp_r[c][7], {16'h0, ctl[c].sweep_rate});
      check("rise_delta", exp_r[c][8], ctl[c].rise_delta);
      check("fall_delta", exp_r[c][9], ctl[c].fall_delta);
      $display("random channel %0d done", c);
    end
    host.wr_word(5'h00, 32'h40);
    host.wr_word(5'h03, 32'h601e);
    host.wr_word(5'h06, 32'h400);
    exp_r[2][3] = 32'h601e;
    exp_r[2][6] = 32'h400;
    host.pulse();
    #1 check("phase_zero", 32'h1, {31'h0, ctl[2].phase_load_zero});
    check("sweep_zero", 32'h1, {31'h0, ctl[2].sweep_load_zero});
    check("sweep_reload", 32'h1, {31'h0, ctl[2].sweep_rr_reload});
    check("sweep_en", 32'h1, {31'h0, ctl[2].sweep_en});
    check("phase_clr", 32'h1, {31'h0, phase_clr_async[2]});
    check("sweep_clr", 32'h1, {31'h0, sweep_clr_async[2]});
    @(posedge ref_clk);
    #1 check("phase_zero_end", 32'h0, {31'h0, ctl[2].phase_load_zero});
    @(posedge ref_clk);
    profile_change <= 1'b1;
    @(posedge ref_clk);
    profile_change <= 1'b0;
    #1 check("amp_reload", 32'h1, {31'h0, ctl[2].amp_rr_reload});
    host.wr_word(5'h02, 32'h8000);
    host.pulse();
    #1 for (int c = 0; c < 4; c++) sz[c] = ctl[c].sweep_load_zero;
    check("global_sweep_zero", 32'hf, {28'h0, sz});
    $display("pulse tests done");
    @(posedge ref_clk);
    clk_en <= 1'b0;
    host.wr_word(5'h04, 32'h12345678);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    host.wr_word(5'h00, 32'h0);
    host.wr_word(5'h04, 32'h87654321);
    host.pulse(2);
    for (int c = 0; c < 4; c++) rd(4, c);
    rd(31, 0);
    exp_r[0][2] = 32'h8000;
    rd(0, 0);
    rd(2, 0);
    $display("refusal tests done");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (exp_r[c, a]) exp_r[c][a] = 32'h0;
    @(posedge ref_clk);
    #1 check("chan_en_reset", 32'hf, {28'h0, chan_en});
    rd(3, 2);
    rd(2, 0);
    $display("reset tests done");
    end_sim();
  end
endmodule
